// ==== src/mbsm_server.sv ====
// modbus server request handler over a shared word database
// assumes one deframed single-item request at a time, synchronous inputs
// How it works
// - one word store shared by ports 502, 2000 and the local port
// - function code picks read or write
// - holding 40001.. maps to holding base word..
// - words 4000..9999 only for float requests
// - float mode only for codes 3,6,16
// - address at or above float start is float
// - float start served from float storage base
// - float n uses base+2n and base+2n+1
// - coils map bitwise from coil base word
// - code 2 adds discrete input base
// - codes 3,6,16 add holding base
// - code 4 adds input word base
// - idle connection closed after timeout
// - ports 502 and 2000 served from store
// - five connections per service port
// - port 2001 passed through to serial master
// - gateway status words writable into store
// - client engine accesses store via own port
module mbsm_server #(
    parameter int unsigned SEC_CYC = mbsm_pkg::SEC_CYCLES
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // configuration
    input wire mbsm_pkg::mbsm_cfg_s cfg_i,
    input wire logic serial_master_i,
    // connection events from the network stack
    input wire logic open_i,
    input wire logic [15:0] open_port_i,
    input wire logic rx_i,
    input wire logic [3:0] rx_conn_i,
    output logic open_ok_o,
    output logic open_done_o,
    output logic [3:0] open_conn_o,
    output logic close_o,
    output logic [3:0] close_conn_o,
    // server requests and answers
    input wire logic req_valid_i,
    input wire mbsm_pkg::mbsm_req_s req_i,
    output logic rsp_valid_o,
    output mbsm_pkg::mbsm_rsp_s rsp_o,
    // pass-through to serial master
    output logic pass_valid_o,
    output mbsm_pkg::mbsm_req_s pass_o,
    // status and client engine store port
    input wire logic aux_we_i,
    input wire logic [11:0] aux_addr_i,
    input wire logic [15:0] aux_wdata_i,
    output logic [15:0] aux_rdata_o
);
    typedef struct packed {
        logic [mbsm_pkg::NCONN-1:0] used;
        logic [mbsm_pkg::NCONN-1:0][10:0] idle;
        logic [31:0] tick;
        logic open_ok;
        logic open_done;
        logic [3:0] open_conn;
        logic close;
        logic [3:0] close_conn;
        logic rsp_valid;
        mbsm_pkg::mbsm_rsp_s rsp;
        logic pass_valid;
        mbsm_pkg::mbsm_req_s pass;
        logic [15:0] aux_rdata;
    } st_s;

    st_s st_r, st_nxt;
    // shared store; kept outside the struct so it maps onto a ram
    logic [15:0] db_r [mbsm_pkg::DB_WORDS];

    // word index plus bit for coils
    logic hit;
    logic we;
    logic [11:0] widx;
    logic [3:0] bsel;
    logic [7:0] exc;
    logic [17:0] fidx;
    logic [16:0] sum;
    logic is_float;
    mbsm_pkg::mbsm_req_s rq;

    function automatic logic fc_hold(input logic [7:0] f);
        return f == mbsm_pkg::FC_RD_HOLD || f == mbsm_pkg::FC_WR_HOLD ||
            f == mbsm_pkg::FC_WR_HOLDS;
    endfunction

    // decode of one request into word, bit and direction
    always_comb begin
        rq = req_i;
        we = 1'b0;
        widx = 12'h000;
        bsel = 4'h0;
        exc = 8'h00;
        sum = 17'h0_0000;
        fidx = 18'h0_0000;
        is_float = cfg_i.float_en && fc_hold(rq.func) &&
            rq.addr >= cfg_i.float_start;
        unique case (rq.func)
            mbsm_pkg::FC_RD_COIL, mbsm_pkg::FC_WR_COIL,
            mbsm_pkg::FC_WR_COILS: begin
                sum = {5'h00, cfg_i.coil_base} + {5'h00, rq.addr[15:4]};
                bsel = rq.addr[3:0];
                we = rq.func != mbsm_pkg::FC_RD_COIL;
            end
            mbsm_pkg::FC_RD_DISC: begin
                sum = {5'h00, cfg_i.disc_base} + {1'b0, rq.addr};
            end
            mbsm_pkg::FC_RD_INP: begin
                sum = {5'h00, cfg_i.inp_base} + {1'b0, rq.addr};
            end
            mbsm_pkg::FC_RD_HOLD, mbsm_pkg::FC_WR_HOLD,
            mbsm_pkg::FC_WR_HOLDS: begin
                we = rq.func != mbsm_pkg::FC_RD_HOLD;
                if (is_float) begin
                    // low word of the pair only; high word at +1
                    fidx = {6'h00, cfg_i.float_base} +
                        {1'b0, rq.addr - cfg_i.float_start, 1'b0};
                    sum = fidx[17] ? 17'h1_FFFF : fidx[16:0];
                end else begin
                    sum = {5'h00, cfg_i.hold_base} + {1'b0, rq.addr};
                end
            end
            default: exc = mbsm_pkg::EXC_FUNC;
        endcase
        // virtual range is refused unless reached as float
        if (exc == 8'h00 && sum > {1'b0, mbsm_pkg::DB_LAST}) begin
            exc = mbsm_pkg::EXC_ADDR;
        end
        widx = sum[11:0];
        hit = req_valid_i && exc == 8'h00 &&
            (rq.port == mbsm_pkg::PORT_MBAP ||
             rq.port == mbsm_pkg::PORT_ENCAP);
    end

    // connection slots: 0..4 for mbap, 5..9 for encapsulated
    logic [3:0] free_slot;
    logic free_found;
    logic [3:0] lo;
    always_comb begin
        free_slot = 4'h0;
        free_found = 1'b0;
        lo = (open_port_i == mbsm_pkg::PORT_ENCAP) ? 4'h5 : 4'h0;
        for (int i = mbsm_pkg::CONN_MAX - 1; i >= 0; i--) begin
            if (!st_r.used[lo + 4'(i)]) begin
                free_slot = lo + 4'(i);
                free_found = 1'b1;
            end
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.open_done = 1'b0;
        st_nxt.open_ok = 1'b0;
        st_nxt.close = 1'b0;
        st_nxt.rsp_valid = 1'b0;
        st_nxt.pass_valid = 1'b0;
        st_nxt.aux_rdata = db_r[aux_addr_i];
        st_nxt.tick = (st_r.tick >= SEC_CYC - 1) ? 32'h0000_0000 :
            st_r.tick + 32'h0000_0001;
        if (open_i) begin
            st_nxt.open_done = 1'b1;
            st_nxt.open_conn = free_slot;
            if ((open_port_i == mbsm_pkg::PORT_MBAP ||
                 open_port_i == mbsm_pkg::PORT_ENCAP) && free_found) begin
                st_nxt.open_ok = 1'b1;
                st_nxt.used[free_slot] = 1'b1;
                st_nxt.idle[free_slot] = 11'h000;
            end
        end
        // idle count in seconds; one closing per cycle, others wait
        for (int i = 0; i < mbsm_pkg::NCONN; i++) begin
            if (st_r.tick == 32'h0000_0000 && st_r.used[i] &&
                st_r.idle[i] != mbsm_pkg::TMO_MAX_S) begin
                st_nxt.idle[i] = st_r.idle[i] + 11'h001;
            end
            if (rx_i && rx_conn_i == 4'(i)) begin
                st_nxt.idle[i] = 11'h000;
            end
        end
        for (int i = mbsm_pkg::NCONN - 1; i >= 0; i--) begin
            if (st_r.used[i] && st_r.idle[i] >= cfg_i.idle_s &&
                !(rx_i && rx_conn_i == 4'(i))) begin
                st_nxt.close = 1'b1;
                st_nxt.close_conn = 4'(i);
            end
        end
        if (st_nxt.close) begin
            st_nxt.used[st_nxt.close_conn] = 1'b0;
        end
        if (req_valid_i && req_i.port == mbsm_pkg::PORT_PASS) begin
            st_nxt.pass_valid = serial_master_i;
            st_nxt.pass = req_i;
        end else if (req_valid_i) begin
            st_nxt.rsp_valid = 1'b1;
            st_nxt.rsp.conn = req_i.conn;
            st_nxt.rsp.exc = !hit;
            st_nxt.rsp.code = hit ? req_i.func :
                (exc != 8'h00 ? exc : mbsm_pkg::EXC_FUNC);
            st_nxt.rsp.rdata = hit ? (bsel != 4'h0 ||
                req_i.func == mbsm_pkg::FC_RD_COIL ?
                {15'h0000, db_r[widx][bsel]} : db_r[widx]) : 16'h0000;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // store writes; network write wins over the local port on a clash
    always_ff @(posedge clock_i) begin
        if (aux_we_i) begin
            db_r[aux_addr_i] <= aux_wdata_i;
        end
        if (hit && we) begin
            if (req_i.func == mbsm_pkg::FC_WR_COIL ||
                req_i.func == mbsm_pkg::FC_WR_COILS) begin
                db_r[widx][bsel] <= req_i.wdata[0];
            end else begin
                db_r[widx] <= req_i.wdata;
            end
        end
    end

    assign open_ok_o = st_r.open_ok;
    assign open_done_o = st_r.open_done;
    assign open_conn_o = st_r.open_conn;
    assign close_o = st_r.close;
    assign close_conn_o = st_r.close_conn;
    assign rsp_valid_o = st_r.rsp_valid;
    assign rsp_o = st_r.rsp;
    assign pass_valid_o = st_r.pass_valid;
    assign pass_o = st_r.pass;
    assign aux_rdata_o = st_r.aux_rdata;
endmodule

// ==== src/mbsm_pkg.sv ====
// constants and carrier types for the modbus server address map
// assumes a 50 MHz clock and requests already deframed by the network side
package mbsm_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned DB_WORDS = 4000;
    localparam int unsigned VIRT_LAST = 9999;
    localparam logic [15:0] DB_LAST = 16'h0F9F;
    localparam logic [15:0] VIRT_END = 16'h270F;
    localparam logic [15:0] PORT_MBAP = 16'h01F6;
    localparam logic [15:0] PORT_ENCAP = 16'h07D0;
    localparam logic [15:0] PORT_PASS = 16'h07D1;
    localparam int unsigned CONN_MAX = 5;
    localparam int unsigned NCONN = 10;
    localparam logic [10:0] TMO_MAX_S = 11'h04B0;
    localparam int unsigned SEC_CYCLES = CLK_HZ;
    localparam logic [7:0] FC_RD_COIL = 8'h01;
    localparam logic [7:0] FC_RD_DISC = 8'h02;
    localparam logic [7:0] FC_RD_HOLD = 8'h03;
    localparam logic [7:0] FC_RD_INP = 8'h04;
    localparam logic [7:0] FC_WR_COIL = 8'h05;
    localparam logic [7:0] FC_WR_HOLD = 8'h06;
    localparam logic [7:0] FC_WR_COILS = 8'h0F;
    localparam logic [7:0] FC_WR_HOLDS = 8'h10;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;

    typedef struct packed {
        logic [3:0] conn;
        logic [15:0] port;
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mbsm_req_s;

    typedef struct packed {
        logic [3:0] conn;
        logic exc;
        logic [7:0] code;
        logic [15:0] rdata;
    } mbsm_rsp_s;

    typedef struct packed {
        logic float_en;
        logic [15:0] float_start;
        logic [11:0] float_base;
        logic [11:0] coil_base;
        logic [11:0] disc_base;
        logic [11:0] hold_base;
        logic [11:0] inp_base;
        logic [10:0] idle_s;
    } mbsm_cfg_s;
endpackage

// ==== tb/mbsm_server_sva.sv ====
// checker for the server request handler, watching its ports only
// assumes a single clock domain and the async active-low reset
module mbsm_server_sva (
    // clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // watched ports
    input wire mbsm_pkg::mbsm_cfg_s cfg_i,
    input wire logic serial_master_i,
    input wire logic open_i,
    input wire logic [15:0] open_port_i,
    input wire logic req_valid_i,
    input wire mbsm_pkg::mbsm_req_s req_i,
    input wire logic rsp_valid_o,
    input wire mbsm_pkg::mbsm_rsp_s rsp_o,
    input wire logic pass_valid_o,
    input wire mbsm_pkg::mbsm_req_s pass_o,
    input wire logic open_done_o,
    input wire logic open_ok_o,
    input wire logic [3:0] open_conn_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_srv;
        req_valid_i && (req_i.port == mbsm_pkg::PORT_MBAP ||
            req_i.port == mbsm_pkg::PORT_ENCAP);
    endsequence
    sequence s_pass;
        req_valid_i && req_i.port == mbsm_pkg::PORT_PASS;
    endsequence
    property p_lat;
        s_srv |=> rsp_valid_o && !pass_valid_o;
    endproperty
    property p_conn;
        s_srv |=> rsp_o.conn == $past(req_i.conn);
    endproperty
    property p_func;
        s_srv ##0 req_i.func == 8'h07 |=> rsp_o.exc && rsp_o.code == 8'h01;
    endproperty
    // holding words past the store, outside the float window
    property p_range;
        s_srv ##0 req_i.func == mbsm_pkg::FC_RD_HOLD ##0
        (!cfg_i.float_en || req_i.addr < cfg_i.float_start) ##0
        ({1'b0, req_i.addr} + cfg_i.hold_base > 17'h0_0F9F)
        |=> rsp_o.exc && rsp_o.code == mbsm_pkg::EXC_ADDR;
    endproperty
    property p_pass;
        s_pass ##0 serial_master_i
        |=> pass_valid_o && pass_o == $past(req_i) && !rsp_valid_o;
    endproperty
    property p_drop;
        s_pass ##0 !serial_master_i |=> !pass_valid_o && !rsp_valid_o;
    endproperty
    property p_open;
        open_i |=> open_done_o;
    endproperty
    property p_slot;
        open_i && open_port_i == mbsm_pkg::PORT_MBAP
        |=> !open_ok_o || open_conn_o < 4'h5;
    endproperty
    property p_slot2;
        open_i && open_port_i == mbsm_pkg::PORT_ENCAP
        |=> !open_ok_o || (open_conn_o > 4'h4 && open_conn_o < 4'hA);
    endproperty
    a_lat: assert property (p_lat) else $error("no answer");
    a_conn: assert property (p_conn) else $error("wrong slot");
    a_func: assert property (p_func) else $error("no func exc");
    a_range: assert property (p_range) else $error("no addr exc");
    a_pass: assert property (p_pass) else $error("no pass");
    a_drop: assert property (p_drop) else $error("not dropped");
    a_open: assert property (p_open) else $error("no open answer");
    a_slot: assert property (p_slot) else $error("bad slot");
    a_slot2: assert property (p_slot2) else $error("bad slot");
endmodule

bind mbsm_server mbsm_server_sva u_sva (.clock_i, .arst_n_i, .cfg_i,
    .serial_master_i, .open_i, .open_port_i, .req_valid_i, .req_i,
    .rsp_valid_o, .rsp_o, .pass_valid_o, .pass_o, .open_done_o,
    .open_ok_o, .open_conn_o);

// ==== tb/mbsm_client_model.sv ====
// remote network client: issues one request per call
// assumes the caller enters send at a falling edge
module mbsm_client_model (
    // clock
    input wire logic clock_i,
    // request towards the handler
    output logic req_valid_o,
    output mbsm_pkg::mbsm_req_s req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end
    task automatic send(input logic [7:0] f, input logic [15:0] p,
            input logic [15:0] a, input logic [15:0] w);
        req_o = '{4'h1, p, f, a, w};
        req_valid_o = 1'b1;
        @(negedge clock_i);
        req_valid_o = 1'b0;
        // released fields scrambled so no stale value passes
        req_o = ~req_o;
    endtask
endmodule

// ==== tb/modbus_server_address_map_bench.sv ====
// self-checking bench for the server request handler
// assumes a short second count so idle closes happen quickly
module modbus_server_address_map_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] f;
        logic [15:0] p;
        logic [15:0] a;
        logic [15:0] w;
        logic e;
        logic k;
        logic [15:0] d;
    } mbsm_row_s;
    // d is the exception code when e, read data when k
    localparam mbsm_row_s rows [12] = '{
        '{8'h06, 16'h01F6, 16'h0000, 16'h1234, 1'b0, 1'b0, 16'h0000},
        '{8'h03, 16'h07D0, 16'h0000, 16'h0000, 1'b0, 1'b1, 16'h1234},
        '{8'h10, 16'h01F6, 16'h0001, 16'hBEEF, 1'b0, 1'b0, 16'h0000},
        '{8'h03, 16'h01F6, 16'h0001, 16'h0000, 1'b0, 1'b1, 16'hBEEF},
        '{8'h04, 16'h01F6, 16'h0005, 16'h0000, 1'b0, 1'b1, 16'hA5A5},
        '{8'h02, 16'h07D0, 16'h0000, 16'h0000, 1'b0, 1'b1, 16'h5A5A},
        '{8'h05, 16'h01F6, 16'h0003, 16'h0001, 1'b0, 1'b0, 16'h0000},
        '{8'h01, 16'h01F6, 16'h0003, 16'h0000, 1'b0, 1'b1, 16'h0001},
        '{8'h03, 16'h01F6, 16'h1B59, 16'h0000, 1'b0, 1'b1, 16'hC0DE},
        '{8'h03, 16'h01F6, 16'h0F6E, 16'h0000, 1'b1, 1'b0, 16'h0002},
        '{8'h07, 16'h01F6, 16'h0000, 16'h0000, 1'b1, 1'b0, 16'h0001},
        '{8'h03, 16'h0050, 16'h0000, 16'h0000, 1'b1, 1'b0, 16'h0001}};
    localparam logic [11:0] pre_a [4] = '{12'h069, 12'h096, 12'h014, 12'hBBA};
    localparam logic [15:0] pre_d [4] = '{16'hA5A5, 16'h5A5A, 16'h0004,
        16'hC0DE};
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic smast = 1'b0;
    logic open = 1'b0;
    logic aux_we = 1'b0;
    logic [15:0] oport = 16'h0000;
    logic [15:0] aux_wd = 16'h0000;
    logic [11:0] aux_a = 12'h000;
    mbsm_pkg::mbsm_cfg_s cfg = '{1'b1, 16'h1B58, 12'hBB8, 12'h014, 12'h096,
        12'h032, 12'h064, 11'h4B0};
    logic req_v, rsp_v, pass_v, ok, done, cls;
    logic [3:0] oconn;
    logic [15:0] aux_rd;
    mbsm_pkg::mbsm_req_s req, pass;
    mbsm_pkg::mbsm_rsp_s rsp;
    int total_checks = 0;
    int miscompares = 0;
    int n;
    always #10 clock = ~clock;
    mbsm_client_model cli (.clock_i(clock), .req_valid_o(req_v), .req_o(req));
    mbsm_server #(.SEC_CYC(10)) uut (.clock_i(clock), .arst_n_i(arst_n),
        .cfg_i(cfg), .serial_master_i(smast), .open_i(open),
        .open_port_i(oport), .rx_i(1'b0), .rx_conn_i(4'h0), .open_ok_o(ok),
        .open_done_o(done), .open_conn_o(oconn), .close_o(cls),
        .close_conn_o(), .req_valid_i(req_v), .req_i(req),
        .rsp_valid_o(rsp_v), .rsp_o(rsp), .pass_valid_o(pass_v),
        .pass_o(pass), .aux_we_i(aux_we), .aux_addr_i(aux_a),
        .aux_wdata_i(aux_wd), .aux_rdata_o(aux_rd));
    task automatic check(input string name, input logic [15:0] seen,
            input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clock);
        check("rsp_valid in reset", rsp_v, 1'b0);
        arst_n = 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(negedge clock);
            {aux_we, aux_a, aux_wd} = {1'b1, pre_a[i], pre_d[i]};
        end
        @(negedge clock);
        aux_we = 1'b0;
        for (int i = 0; i < 12; i++) begin
            @(negedge clock);
            cli.send(rows[i].f, rows[i].p, rows[i].a, rows[i].w);
            check("rsp_valid", rsp_v, 1'b1);
            check("exc", rsp.exc, rows[i].e);
            if (rows[i].e || rows[i].k)
                check("data", rows[i].e ? rsp.code : rsp.rdata, rows[i].d);
        end
        // fc6 wrote word 50; seen through the local port
        aux_a = 12'h032;
        @(negedge clock);
        check("aux_rdata", aux_rd, 16'h1234);
        cfg.float_en = 1'b0;
        @(negedge clock);
        cli.send(8'h03, 16'h01F6, 16'h1B59, 16'h0000);
        check("code", rsp.code, 16'h0002);
        smast = 1'b1;
        @(negedge clock);
        cli.send(8'h03, 16'h07D1, 16'h0007, 16'h0000);
        check("pass_addr", pass_v ? pass.addr : 16'hFFFF, 16'h0007);
        smast = 1'b0;
        @(negedge clock);
        cli.send(8'h03, 16'h07D1, 16'h0007, 16'h0000);
        check("pass_valid", pass_v | rsp_v, 1'b0);
        for (int i = 0; i < 7; i++) begin
            @(negedge clock);
            open = 1'b1;
            oport = i < 6 ? 16'h01F6 : 16'h07D0;
            @(negedge clock);
            open = 1'b0;
            check("open_ok", {done, ok}, {1'b1, i != 5});
            if (i != 5)
                check("open_conn", oconn, i < 6 ? i : 5);
        end
        cfg.idle_s = 11'h001;
        n = 0;
        repeat (60) begin
            @(negedge clock);
            n += cls;
        end
        check("closes", n[15:0], 16'h0006);
        print_verdict();
    end
    // the tests need well under a thousand cycles
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end
endmodule
